//--- hw/sscsr_pkg.sv
// constants, register map and carrier types of the serial slave register bank
// assumes one system clock; register numbers are used directly as addresses
package sscsr_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SEC_NS = 1_000_000_000;
  localparam int MS_NS = 1_000_000;
  localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  localparam logic [15:0] ADDR_CFG_CHANGES = 16'h0054;
  localparam logic [15:0] ADDR_DP_SCALED = 16'h0074;
  localparam logic [15:0] ADDR_SP_SCALED = 16'h0075;
  localparam logic [15:0] ADDR_PT_SCALED = 16'h0076;
  localparam logic [15:0] ADDR_STATUS_HI = 16'h0077;
  localparam logic [15:0] ADDR_STATUS_MID = 16'h0078;
  localparam logic [15:0] ADDR_STATUS_LO = 16'h0079;
  localparam logic [15:0] ADDR_MAX_SCALE = 16'h007d;
  localparam logic [15:0] ADDR_SCROLL_SEC = 16'h007e;
  localparam logic [15:0] ADDR_DISP_MASK_HI = 16'h007f;
  localparam logic [15:0] ADDR_DISP_MASK_LO = 16'h0080;
  localparam logic [15:0] ADDR_TURNAROUND = 16'h0083;
  localparam logic [15:0] ADDR_FLOAT_ORDER = 16'h0084;
  localparam logic [15:0] ADDR_RATE_SEL = 16'h0085;
  localparam logic [15:0] ADDR_TEMP_MODE = 16'h0086;
  localparam logic [15:0] ADDR_RTD_WIRING = 16'h0087;
  localparam logic [15:0] ADDR_FRAMING_CNT = 16'h0091;
  localparam logic [15:0] ADDR_OVERRUN_CNT = 16'h0093;
  localparam logic [15:0] ADDR_CRC_CNT = 16'h0094;
  localparam logic [15:0] ADDR_GOOD_CNT = 16'h0096;

  // implemented display item bits: 0..5, 7, 8..13, 16..18
  localparam logic [31:0] DISP_MASK_VALID = 32'h0007_3fbf;
  localparam logic [31:0] RST_DISP_MASK = 32'h0000_0001;
  localparam logic [15:0] RST_SCROLL_SEC = 16'h0003;
  localparam logic [15:0] RST_MAX_SCALE = 16'hffff;
  localparam logic [15:0] RST_TURNAROUND = 16'h0000;
  localparam logic [2:0] RATE_1200 = 3'h1;
  localparam logic [2:0] RATE_2400 = 3'h2;
  localparam logic [2:0] RATE_4800 = 3'h3;
  localparam logic [2:0] RATE_9600 = 3'h4;
  localparam logic [2:0] RATE_19200 = 3'h5;
  localparam logic [2:0] RST_RATE = RATE_9600;
  localparam int BAUD_1200 = 1200;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam logic [1:0] FLOAT_ORDER_MAX = 2'h3;
  localparam logic [1:0] RST_FLOAT_ORDER = 2'h0;

  typedef enum logic [1:0] {
    TEMP_FIXED = 2'b00,
    TEMP_NORMAL = 2'b01,
    TEMP_BACKUP = 2'b10
  } sscsr_temp_mode_type;
  localparam sscsr_temp_mode_type RST_TEMP_MODE = TEMP_NORMAL;

  typedef enum logic {
    RTD_FOUR_WIRE = 1'b0,
    RTD_THREE_WIRE = 1'b1
  } sscsr_rtd_type;
  localparam sscsr_rtd_type RST_RTD = RTD_FOUR_WIRE;

  typedef enum logic {
    TA_IDLE = 1'b0,
    TA_WAIT = 1'b1
  } sscsr_ta_state_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sscsr_req_type;

  typedef struct packed {
    logic framing_err;
    logic overrun;
    logic crc_fail;
    logic frame_good;
  } sscsr_evt_type;
endpackage

//--- hw/sscsr_top.sv
// register bank of the serial slave: settings, process values, diagnostics
// assumes a protocol engine outside that decodes frames, issues register
// requests and reports receive events as one-cycle pulses
// Behaviour
// - serial bit tick follows the rate code
// - float bytes reordered by four-way selector
// - temperature mode fixed, normal or backup
// - sensor wiring: four-wire or three-wire
// - display shows items set in mask
// - each item scrolled to held for dwell seconds, one second when dwell is zero
// - reply waits turnaround milliseconds after request
// - count framing errors
// - count receiver overruns
// - count crc failures
// - count good frames
// - count configuration changes; a write and I_CFG_CHANGE in one cycle count once
// - scaled process values read-only
`timescale 1ns/100ps
module sscsr_top #(
  parameter int CLK_HZ = sscsr_pkg::CLK_HZ,
  parameter int CYC_PER_SEC = sscsr_pkg::CYC_PER_SEC,
  parameter int CYC_PER_MS = sscsr_pkg::CYC_PER_MS
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire sscsr_pkg::sscsr_req_type I_REG_REQ,
  output logic [15:0] O_REG_RDATA,
  output logic O_REG_ACK,
  output logic O_REG_ERR,
  input wire logic [15:0] I_DP_SCALED,
  input wire logic [15:0] I_SP_SCALED,
  input wire logic [15:0] I_PT_SCALED,
  input wire logic [47:0] I_XMTR_STATUS,
  input wire sscsr_pkg::sscsr_evt_type I_RX_EVT,
  input wire logic I_CFG_CHANGE,
  input wire logic I_REQ_END,
  output logic O_REPLY_GO,
  output logic O_BIT_TICK,
  input wire logic [31:0] I_FLOAT_VALUE,
  output logic [31:0] O_FLOAT_TX,
  output logic [1:0] O_TEMP_MODE,
  output logic O_RTD_THREE_WIRE,
  output logic [4:0] O_DISP_ITEM,
  output logic O_DISP_VALID,
  output logic [15:0] O_MAX_SCALE
);
  import sscsr_pkg::*;

  if (CLK_HZ / BAUD_19200 < 2) begin : g_chk_clk
    $error("clock too slow for highest serial rate");
  end
  if (CYC_PER_SEC < 1 || CYC_PER_MS < 1) begin : g_chk_tick
    $error("tick counts must be at least one");
  end

  function automatic logic [31:0] baud_div(input logic [2:0] code);
    logic [31:0] r;
    case (code)
      RATE_1200: r = 32'(CLK_HZ / BAUD_1200);
      RATE_2400: r = 32'(CLK_HZ / BAUD_2400);
      RATE_4800: r = 32'(CLK_HZ / BAUD_4800);
      RATE_9600: r = 32'(CLK_HZ / BAUD_9600);
      RATE_19200: r = 32'(CLK_HZ / BAUD_19200);
      default: r = 32'(CLK_HZ / BAUD_9600);
    endcase
    return r;
  endfunction

  function automatic logic [31:0] reorder(input logic [31:0] v,
                                          input logic [1:0] fmt);
    logic [31:0] r;
    case (fmt)
      2'h0: r = v;
      2'h1: r = {v[15:0], v[31:16]};
      2'h2: r = {v[7:0], v[15:8], v[23:16], v[31:24]};
      2'h3: r = {v[23:16], v[31:24], v[7:0], v[15:8]};
      default: r = v;
    endcase
    return r;
  endfunction

  // next set bit after cur, searching round the mask
  function automatic logic [4:0] next_item(input logic [31:0] m,
                                           input logic [4:0] cur);
    logic [4:0] r;
    logic [4:0] idx;
    logic found;
    r = cur;
    found = 1'b0;
    for (int k = 1; k <= 32; k++) begin
      idx = 5'(int'(cur) + k);
      if (!found && m[idx]) begin
        r = idx;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  logic [15:0] max_scale_q;
  logic [15:0] scroll_sec_q;
  logic [31:0] disp_mask_q;
  logic [15:0] turnaround_q;
  logic [1:0] float_order_q;
  logic [2:0] rate_q;
  sscsr_temp_mode_type temp_mode_q;
  sscsr_rtd_type rtd_q;
  logic [15:0] cfg_cnt_q;
  logic [15:0] framing_cnt_q;
  logic [15:0] overrun_cnt_q;
  logic [15:0] crc_cnt_q;
  logic [15:0] good_cnt_q;
  logic [15:0] rdata_d;
  logic mapped_d;
  logic wr_ok_d;
  logic req_d;
  logic [15:0] wd;

  assign req_d = I_REG_REQ.rd | I_REG_REQ.wr;
  assign wd = I_REG_REQ.wdata;

  // read mux and write legality
  always_comb begin
    rdata_d = 16'h0000;
    mapped_d = 1'b1;
    wr_ok_d = 1'b0;
    case (I_REG_REQ.addr)
      ADDR_CFG_CHANGES: rdata_d = cfg_cnt_q;
      ADDR_DP_SCALED: rdata_d = I_DP_SCALED;
      ADDR_SP_SCALED: rdata_d = I_SP_SCALED;
      ADDR_PT_SCALED: rdata_d = I_PT_SCALED;
      ADDR_STATUS_HI: rdata_d = I_XMTR_STATUS[47:32];
      ADDR_STATUS_MID: rdata_d = I_XMTR_STATUS[31:16];
      ADDR_STATUS_LO: rdata_d = I_XMTR_STATUS[15:0];
      ADDR_MAX_SCALE: begin
        rdata_d = max_scale_q;
        wr_ok_d = 1'b1;
      end
      ADDR_SCROLL_SEC: begin
        rdata_d = scroll_sec_q;
        wr_ok_d = 1'b1;
      end
      ADDR_DISP_MASK_HI: begin
        rdata_d = disp_mask_q[31:16];
        wr_ok_d = 1'b1;
      end
      ADDR_DISP_MASK_LO: begin
        rdata_d = disp_mask_q[15:0];
        wr_ok_d = 1'b1;
      end
      ADDR_TURNAROUND: begin
        rdata_d = turnaround_q;
        wr_ok_d = 1'b1;
      end
      ADDR_FLOAT_ORDER: begin
        rdata_d = {14'h0000, float_order_q};
        wr_ok_d = (wd <= 16'(FLOAT_ORDER_MAX));
      end
      ADDR_RATE_SEL: begin
        rdata_d = {13'h0000, rate_q};
        wr_ok_d = (wd >= 16'(RATE_1200)) && (wd <= 16'(RATE_19200));
      end
      ADDR_TEMP_MODE: begin
        rdata_d = {14'h0000, temp_mode_q};
        wr_ok_d = (wd <= 16'(TEMP_BACKUP));
      end
      ADDR_RTD_WIRING: begin
        rdata_d = {15'h0000, rtd_q};
        wr_ok_d = (wd <= 16'(RTD_THREE_WIRE));
      end
      ADDR_FRAMING_CNT: rdata_d = framing_cnt_q;
      ADDR_OVERRUN_CNT: rdata_d = overrun_cnt_q;
      ADDR_CRC_CNT: rdata_d = crc_cnt_q;
      ADDR_GOOD_CNT: rdata_d = good_cnt_q;
      default: mapped_d = 1'b0;
    endcase
  end

  logic wr_take;
  assign wr_take = I_REG_REQ.wr & wr_ok_d;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_REG_ACK <= 1'b0;
      O_REG_ERR <= 1'b0;
      O_REG_RDATA <= 16'h0000;
    end else begin
      O_REG_ACK <= req_d;
      O_REG_ERR <= req_d & (!mapped_d | (I_REG_REQ.wr & !wr_ok_d));
      O_REG_RDATA <= (I_REG_REQ.rd & !I_REG_REQ.wr) ? rdata_d : 16'h0000;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      max_scale_q <= RST_MAX_SCALE;
      scroll_sec_q <= RST_SCROLL_SEC;
      disp_mask_q <= RST_DISP_MASK;
      turnaround_q <= RST_TURNAROUND;
      float_order_q <= RST_FLOAT_ORDER;
      rate_q <= RST_RATE;
      temp_mode_q <= RST_TEMP_MODE;
      rtd_q <= RST_RTD;
    end else if (wr_take) begin
      case (I_REG_REQ.addr)
        ADDR_MAX_SCALE: max_scale_q <= wd;
        ADDR_SCROLL_SEC: scroll_sec_q <= wd;
        ADDR_DISP_MASK_HI: disp_mask_q[31:16] <= wd & DISP_MASK_VALID[31:16];
        ADDR_DISP_MASK_LO: disp_mask_q[15:0] <= wd & DISP_MASK_VALID[15:0];
        ADDR_TURNAROUND: turnaround_q <= wd;
        ADDR_FLOAT_ORDER: float_order_q <= wd[1:0];
        ADDR_RATE_SEL: rate_q <= wd[2:0];
        ADDR_TEMP_MODE: temp_mode_q <= sscsr_temp_mode_type'(wd[1:0]);
        ADDR_RTD_WIRING: rtd_q <= sscsr_rtd_type'(wd[0]);
        default: max_scale_q <= max_scale_q;
      endcase
    end
  end

  // diagnostics counters wrap through zero
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_cnt_q <= 16'h0000;
      framing_cnt_q <= 16'h0000;
      overrun_cnt_q <= 16'h0000;
      crc_cnt_q <= 16'h0000;
      good_cnt_q <= 16'h0000;
    end else begin
      if (wr_take | I_CFG_CHANGE)
        cfg_cnt_q <= cfg_cnt_q + 16'h0001;
      if (I_RX_EVT.framing_err)
        framing_cnt_q <= framing_cnt_q + 16'h0001;
      if (I_RX_EVT.overrun)
        overrun_cnt_q <= overrun_cnt_q + 16'h0001;
      if (I_RX_EVT.crc_fail)
        crc_cnt_q <= crc_cnt_q + 16'h0001;
      if (I_RX_EVT.frame_good)
        good_cnt_q <= good_cnt_q + 16'h0001;
    end
  end

  // serial bit-rate enable
  logic [31:0] baud_cnt_q;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      baud_cnt_q <= 32'h0000_0000;
      O_BIT_TICK <= 1'b0;
    end else if (baud_cnt_q >= baud_div(rate_q) - 32'h0000_0001) begin
      baud_cnt_q <= 32'h0000_0000;
      O_BIT_TICK <= 1'b1;
    end else begin
      baud_cnt_q <= baud_cnt_q + 32'h0000_0001;
      O_BIT_TICK <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FLOAT_TX <= 32'h0000_0000;
      O_TEMP_MODE <= 2'h0;
      O_RTD_THREE_WIRE <= 1'b0;
      O_MAX_SCALE <= 16'h0000;
    end else begin
      O_FLOAT_TX <= reorder(I_FLOAT_VALUE, float_order_q);
      O_TEMP_MODE <= temp_mode_q;
      O_RTD_THREE_WIRE <= (rtd_q == RTD_THREE_WIRE);
      O_MAX_SCALE <= max_scale_q;
    end
  end

  // display scrolling
  logic [31:0] sec_cnt_q;
  logic [15:0] dwell_q;
  logic sec_tick;
  logic [15:0] dwell_lim;
  assign sec_tick = (sec_cnt_q == 32'(CYC_PER_SEC - 1));
  assign dwell_lim = (scroll_sec_q == 16'h0000) ? 16'h0001 : scroll_sec_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sec_cnt_q <= 32'h0000_0000;
      dwell_q <= 16'h0000;
      O_DISP_ITEM <= 5'h00;
      O_DISP_VALID <= 1'b0;
    end else begin
      sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
      O_DISP_VALID <= (disp_mask_q != 32'h0000_0000);
      if (!disp_mask_q[O_DISP_ITEM]) begin
        O_DISP_ITEM <= next_item(disp_mask_q, O_DISP_ITEM);
        dwell_q <= 16'h0000;
      end else if (sec_tick) begin
        if (dwell_q + 16'h0001 >= dwell_lim) begin
          dwell_q <= 16'h0000;
          O_DISP_ITEM <= next_item(disp_mask_q, O_DISP_ITEM);
        end else begin
          dwell_q <= dwell_q + 16'h0001;
        end
      end
    end
  end

  // reply turnaround timer
  sscsr_ta_state_type ta_state_q;
  logic [31:0] ms_cyc_q;
  logic [15:0] ms_cnt_q;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ta_state_q <= TA_IDLE;
      ms_cyc_q <= 32'h0000_0000;
      ms_cnt_q <= 16'h0000;
      O_REPLY_GO <= 1'b0;
    end else if (I_REQ_END) begin
      ta_state_q <= TA_WAIT;
      ms_cyc_q <= 32'h0000_0000;
      ms_cnt_q <= 16'h0000;
      O_REPLY_GO <= 1'b0;
    end else begin
      O_REPLY_GO <= 1'b0;
      case (ta_state_q)
        TA_IDLE: ta_state_q <= TA_IDLE;
        TA_WAIT: begin
          if (ms_cnt_q >= turnaround_q) begin
            O_REPLY_GO <= 1'b1;
            ta_state_q <= TA_IDLE;
          end else if (ms_cyc_q == 32'(CYC_PER_MS - 1)) begin
            ms_cyc_q <= 32'h0000_0000;
            ms_cnt_q <= ms_cnt_q + 16'h0001;
          end else begin
            ms_cyc_q <= ms_cyc_q + 32'h0000_0001;
          end
        end
        default: ta_state_q <= TA_IDLE;
      endcase
    end
  end
endmodule

//--- sim/sscsr_checker.sv
// assertions on the register bank ports
// assumes the bind at the foot attaches it to every sscsr_top
`timescale 1ns/100ps
module sscsr_checker import sscsr_pkg::*; (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire sscsr_pkg::sscsr_req_type I_REG_REQ,
  input wire logic [15:0] O_REG_RDATA,
  input wire logic O_REG_ACK,
  input wire logic O_REG_ERR,
  input wire logic [15:0] I_DP_SCALED,
  input wire logic I_REQ_END,
  input wire logic O_REPLY_GO,
  input wire logic O_BIT_TICK,
  input wire logic [4:0] O_DISP_ITEM,
  input wire logic O_DISP_VALID
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  wire logic req = I_REG_REQ.rd | I_REG_REQ.wr;
  wire logic [15:0] a = I_REG_REQ.addr;
  AST_ACK_NEXT: assert property (req |=> O_REG_ACK)
    else $error("no ack after request");
  AST_ACK_IDLE: assert property (!req |=> !O_REG_ACK)
    else $error("ack without request");
  AST_ERR_WITH_ACK: assert property (O_REG_ERR |-> O_REG_ACK)
    else $error("err outside ack");
  AST_RO_WR_ERR: assert property (I_REG_REQ.wr && a == ADDR_DP_SCALED
    |=> O_REG_ERR) else $error("write to read-only not refused");
  AST_DP_READ: assert property (I_REG_REQ.rd && !I_REG_REQ.wr
    && a == ADDR_DP_SCALED |=> O_REG_RDATA == $past(I_DP_SCALED))
    else $error("scaled value read wrong");
  AST_RDATA_IDLE: assert property (!O_REG_ACK
    |-> O_REG_RDATA == 16'h0)
    else $error("read data outside ack");
  AST_REPLY_PULSE: assert property (O_REPLY_GO |=> !O_REPLY_GO)
    else $error("reply start longer than one cycle");
  AST_REPLY_GAP: assert property (I_REQ_END |=> !O_REPLY_GO)
    else $error("reply started without turnaround");
  AST_TICK_PULSE: assert property (O_BIT_TICK |=> !O_BIT_TICK)
    else $error("bit tick longer than one cycle");
  AST_DISP_ITEM: assert property (O_DISP_VALID
    |-> DISP_MASK_VALID[O_DISP_ITEM])
    else $error("display item not a defined item");
endmodule
bind sscsr_top sscsr_checker u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
  .I_REG_REQ(I_REG_REQ), .O_REG_RDATA(O_REG_RDATA), .O_REG_ACK(O_REG_ACK),
  .O_REG_ERR(O_REG_ERR), .I_DP_SCALED(I_DP_SCALED), .I_REQ_END(I_REQ_END),
  .O_REPLY_GO(O_REPLY_GO), .O_BIT_TICK(O_BIT_TICK),
  .O_DISP_ITEM(O_DISP_ITEM), .O_DISP_VALID(O_DISP_VALID));

//--- sim/sscsr_master_model.sv
// serial master side: one register access per call, one-cycle request
// assumes ack registered on the taking edge itself and sampled 1 ns after it
`timescale 1ns/100ps
module sscsr_master_model (
  input wire logic i_clk,
  output sscsr_pkg::sscsr_req_type o_req,
  input wire logic [15:0] i_rdata,
  input wire logic i_ack,
  input wire logic i_err
);
  import sscsr_pkg::*;
  initial o_req = '0;
  task automatic access(input logic w, input logic [15:0] a, d,
                        output logic [15:0] q, output logic e, k);
    @(posedge i_clk);
    o_req <= {~w, w, a, d};
    @(posedge i_clk);
    o_req <= '0;
    #1;
    q = i_rdata;
    e = i_err;
    k = i_ack;
  endtask
endmodule

//--- sim/test_serial_slave_config_status_regs.sv
// self-checking bench of the register bank with shortened time bases
// assumes the master model and the bound checker
`timescale 1ns/100ps
module test_serial_slave_config_status_regs;
  import sscsr_pkg::*;
  logic clk = 0, rst_n = 0, req_end = 0, cfg_chg = 0;
  sscsr_req_type req;
  sscsr_evt_type evt = '0;
  logic [31:0] ftx, fv = 32'h11223344;
  logic [15:0] dp = 16'h0a5c, sp = 16'h1b6d, pt = 16'h2c7e;
  logic [47:0] st = 48'h0123_4567_89ab;
  logic [15:0] rdata, mx, v;
  logic [4:0] ditem;
  logic [1:0] tmode;
  logic ack, err, go, tick, dval, three, e, k;
  int n_fail = 0, total_checks = 0, cyc = 0, n, m;
  int bauds[5] = '{BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200};
  logic [31:0] fx[4] = '{32'h11223344, 32'h33441122, 32'h44332211,
                         32'h22114433};
  int ds[3] = '{18, 7, 18};
  sscsr_master_model m0 (.i_clk(clk), .o_req(req), .i_rdata(rdata),
    .i_ack(ack), .i_err(err));
  sscsr_top #(.CLK_HZ(192000), .CYC_PER_SEC(20), .CYC_PER_MS(4)) dut (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REG_REQ(req), .O_REG_RDATA(rdata),
    .O_REG_ACK(ack), .O_REG_ERR(err), .I_DP_SCALED(dp),
    .I_SP_SCALED(sp), .I_PT_SCALED(pt),
    .I_XMTR_STATUS(st), .I_RX_EVT(evt), .I_CFG_CHANGE(cfg_chg),
    .I_REQ_END(req_end), .O_REPLY_GO(go), .O_BIT_TICK(tick),
    .I_FLOAT_VALUE(fv), .O_FLOAT_TX(ftx), .O_TEMP_MODE(tmode),
    .O_RTD_THREE_WIRE(three), .O_DISP_ITEM(ditem), .O_DISP_VALID(dval),
    .O_MAX_SCALE(mx));
  initial forever #2.5 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      report_and_stop;
    end
  end
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    total_checks++;
    if (x !== g) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic wr(logic [15:0] a, d, logic x);
    m0.access(1, a, d, v, e, k);
    chk("ack", 1, k);
    chk("err", x, e);
  endtask
  task automatic rd(logic [15:0] a, d);
    m0.access(0, a, 0, v, e, k);
    chk("ack", 1, k);
    chk("err", 0, e);
    chk("rdata", d, v);
  endtask
  task automatic step;
    @(posedge clk);
    #1;
    n++;
  endtask
  task automatic t_reset;
    rd(ADDR_RATE_SEL, 4);
    rd(ADDR_FLOAT_ORDER, 0);
    rd(ADDR_TEMP_MODE, 1);
    rd(ADDR_RTD_WIRING, 0);
    rd(ADDR_DISP_MASK_LO, 1);
    rd(ADDR_SCROLL_SEC, 3);
    rd(ADDR_TURNAROUND, 0);
    rd(ADDR_FRAMING_CNT, 0);
    chk("display valid", 1, dval);
  endtask
  task automatic t_rate;
    for (int c = 1; c <= 5; c++) begin
      wr(ADDR_RATE_SEL, c, 0);
      repeat (2) do step(); while (tick !== 1);
      n = 0;
      do step(); while (tick !== 1);
      chk("tick period", 192000 / bauds[c-1], n);
    end
    wr(ADDR_RATE_SEL, 0, 1);
    wr(ADDR_RATE_SEL, 6, 1);
    rd(ADDR_RATE_SEL, 5);
  endtask
  task automatic t_modes;
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_FLOAT_ORDER, f, 0);
      step();
      chk("float tx", fx[f], ftx);
    end
    wr(ADDR_FLOAT_ORDER, 4, 1);
    for (int t = 0; t < 3; t++) begin
      wr(ADDR_TEMP_MODE, t, 0);
      step();
      chk("temp mode", t, tmode);
    end
    wr(ADDR_TEMP_MODE, 3, 1);
    for (int w = 0; w < 2; w++) begin
      wr(ADDR_RTD_WIRING, w, 0);
      step();
      chk("three wire", w, three);
    end
    wr(ADDR_RTD_WIRING, 2, 1);
  endtask
  task automatic t_disp;
    wr(ADDR_SCROLL_SEC, 1, 0);
    // clearing the shown bit makes the item jump at once
    wr(ADDR_DISP_MASK_LO, 16'h00c0, 0);
    rd(ADDR_DISP_MASK_LO, 16'h0080);
    chk("display item", 7, ditem);
    wr(ADDR_DISP_MASK_HI, 16'h0004, 0);
    for (int i = 0; i < 3; i++) begin
      m = ditem;
      n = 0;
      do step(); while (ditem === m && n < 100);
      chk("display item", ds[i], ditem);
      if (i > 0) chk("dwell", 20, n);
    end
    chk("display valid", 1, dval);
    wr(ADDR_DISP_MASK_HI, 16'h0000, 0);
    wr(ADDR_DISP_MASK_LO, 16'h0000, 0);
    step();
    chk("display valid", 0, dval);
  endtask
  task automatic end_pulse;
    @(posedge clk) req_end <= 1;
    @(posedge clk) req_end <= 0;
    #1;
    n = 0;
  endtask
  task automatic t_turn;
    end_pulse();
    do step(); while (go !== 1 && n < 50);
    chk("reply delay 0", 1, n);
    wr(ADDR_TURNAROUND, 2, 0);
    end_pulse();
    repeat (4) step();
    chk("no early reply", 0, go);
    end_pulse();
    do step(); while (go !== 1 && n < 50);
    chk("reply delay 2", 1, n >= 9 && n <= 11);
  endtask
  task automatic ev(logic [3:0] p, int c);
    repeat (c) @(posedge clk) evt <= sscsr_evt_type'(p);
    @(posedge clk) evt <= '0;
  endtask
  task automatic t_count;
    m0.access(0, ADDR_CFG_CHANGES, 0, v, e, k);
    m = v;
    @(posedge clk) cfg_chg <= 1;
    @(posedge clk) cfg_chg <= 0;
    wr(ADDR_MAX_SCALE, 16'h1234, 0);
    wr(ADDR_DP_SCALED, 1, 1);
    wr(ADDR_SP_SCALED, 1, 1);
    rd(ADDR_CFG_CHANGES, m + 2);
    chk("max scale", 16'h1234, mx);
    ev(4'h8, 3);
    ev(4'h4, 2);
    ev(4'h2, 1);
    ev(4'h1, 4);
    rd(ADDR_FRAMING_CNT, 3);
    rd(ADDR_OVERRUN_CNT, 2);
    rd(ADDR_CRC_CNT, 1);
    rd(ADDR_GOOD_CNT, 4);
    ev(4'h1, 65532);
    rd(ADDR_GOOD_CNT, 0);
  endtask
  task automatic t_values;
    rd(ADDR_DP_SCALED, 16'h0a5c);
    rd(ADDR_SP_SCALED, 16'h1b6d);
    rd(ADDR_PT_SCALED, 16'h2c7e);
    rd(ADDR_STATUS_HI, 16'h0123);
    rd(ADDR_STATUS_LO, 16'h89ab);
    rd(ADDR_STATUS_MID, 16'h4567);
    @(posedge clk) begin
      dp <= 16'h5ac0;
      sp <= 16'h6d1b;
      pt <= 16'h7e2c;
      st <= 48'hfedc_ba98_7654;
    end
    rd(ADDR_DP_SCALED, 16'h5ac0);
    rd(ADDR_SP_SCALED, 16'h6d1b);
    rd(ADDR_PT_SCALED, 16'h7e2c);
    rd(ADDR_STATUS_HI, 16'hfedc);
    rd(ADDR_STATUS_MID, 16'hba98);
    rd(ADDR_STATUS_LO, 16'h7654);
    m0.access(0, 16'h0055, 0, v, e, k);
    chk("unmapped err", 1, e);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_rate();
    t_modes();
    t_disp();
    t_turn();
    t_count();
    t_values();
    report_and_stop();
  end
endmodule
